/* core/tmc_capture_filter.sv */
// capture input filter: four equal samples needed before the filtered level moves
`timescale 1ns/1ps
module tmc_capture_filter
    import tmc_pkg::*;
#(
    parameter int LEN = TMC_FILTER_LEN
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic sample_in,
    output logic      level_out
);
    typedef struct packed {
        logic [LEN-1:0] hist;
        logic           level;
    } tmc_flt_state_t;

    tmc_flt_state_t st_reg;
    tmc_flt_state_t st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.hist = {st_reg.hist[LEN-2:0], sample_in};
        if (!enable) begin
            st_next.level = sample_in;
        // judged on the registered history, so a change lands four cycles after the unfiltered path
        end else if (&st_reg.hist) begin
            st_next.level = 1'b1;
        end else if (~|st_reg.hist) begin
            st_next.level = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_out = st_reg.level;

    a_filter_hold: assert property (@(posedge clk) disable iff (rst)
        (enable && $past(enable) && st_reg.level != $past(st_reg.level))
            |-> ($past(st_reg.hist) == {LEN{st_reg.level}}))
        else $error("filtered level moved without four equal samples");
endmodule

/* core/tmc_pkg.sv */
// package: register map, field layout, mode and clock encodings for the timer mode/capture block
package tmc_pkg;
    // ------------------------------------------------------------
    // register indices; the bus byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [11:0] TMC_OFS_CTRL_A    = 12'h0a0;
    localparam logic [11:0] TMC_OFS_CTRL_B    = 12'h0a1;
    localparam logic [11:0] TMC_OFS_COUNTER   = 12'h0a4;
    localparam logic [11:0] TMC_OFS_CAPTURE   = 12'h0a6;
    localparam logic [11:0] TMC_OFS_COMPARE_A = 12'h0a8;
    localparam logic [11:0] TMC_OFS_STATUS    = 12'h0b0;
    localparam logic [11:0] TMC_OFS_MASK      = 12'h0b4;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int          TMC_B_FILTER_BIT  = 7;
    localparam int          TMC_B_EDGE_BIT    = 6;
    localparam int          TMC_B_MODE_HI     = 4;
    localparam int          TMC_B_MODE_LO     = 3;
    localparam int          TMC_B_CSEL_HI     = 2;
    localparam logic [7:0]  TMC_B_WRITE_MASK  = 8'hdf;
    localparam logic [7:0]  TMC_CTRL_RESET    = 8'h00;
    localparam int          TMC_ST_CAPTURE    = 0;
    localparam int          TMC_ST_OVERFLOW   = 1;
    localparam int          TMC_FILTER_LEN    = 4;
    // ------------------------------------------------------------
    // fixed TOP values
    // ------------------------------------------------------------
    localparam logic [15:0] TMC_TOP_8BIT      = 16'h00ff;
    localparam logic [15:0] TMC_TOP_9BIT      = 16'h01ff;
    localparam logic [15:0] TMC_TOP_10BIT     = 16'h03ff;
    localparam logic [15:0] TMC_TOP_MAX       = 16'hffff;
    // ------------------------------------------------------------
    // prescaler divisors
    // ------------------------------------------------------------
    localparam int          TMC_DIV_8         = 8;
    localparam int          TMC_DIV_64        = 64;
    localparam int          TMC_DIV_256       = 256;
    localparam int          TMC_DIV_1024      = 1024;
    localparam int          TMC_PRE_W         = 10;

    typedef enum logic [3:0] {
        TMC_TOP_FIXED   = 4'b0001,
        TMC_TOP_CAPTURE = 4'b0010,
        TMC_TOP_COMPARE = 4'b0100,
        TMC_TOP_NONE    = 4'b1000
    } tmc_top_src_t;

    typedef enum logic [3:0] {
        TMC_KIND_NORMAL = 4'b0001,
        TMC_KIND_CLEAR  = 4'b0010,
        TMC_KIND_PHASE  = 4'b0100,
        TMC_KIND_FAST   = 4'b1000
    } tmc_kind_t;

    typedef struct packed {
        tmc_kind_t    kind;
        tmc_top_src_t top_src;
        logic [15:0]  top_fixed;
        logic         load_at_top;
        logic         load_at_bottom;
        logic         flag_at_top;
        logic         flag_at_bottom;
        logic         reserved;
    } tmc_mode_t;
endpackage

/* core/tmc_timer_ctrl.sv */
// top: APB register file, mode decode, clock select, counter and input capture
//
// Function
// - codes 1-3 phase-correct, 5-7 fast PWM with fixed 8/9/10-bit TOP.
// - codes 8/9 phase-freq, 10/11 phase, 14/15 fast; even capture TOP, odd compare.
// - with filter on, filtered input changes after four equal samples.
// - enabled filter delays capture events by four cycles.
// - edge select zero captures on falling edge, one on rising edge.
// - capture copies counter into capture value and sets capture flag.
// - capture interrupt raised when capture flag set and enabled.
// - capture disabled while capture value serves as TOP.
// - clock select zero stops the counter.
// - codes 1-5 give clock divided by 1, 8, 64, 256, 1024.
// - control B: filter bit7, edge bit6, mode bits 4:3, clock select 2:0.
// - legacy mode-bit positions kept compatible.
// - codes 6 and 7 count falling and rising edges of external pin.
// - lower mode bits in control A combine with upper bits of control B.
`timescale 1ns/1ps
module tmc_timer_ctrl
    import tmc_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        SYS_RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        CAPTURE_IN,
    input  wire logic        EXT_COUNT_IN,
    output logic             IRQ
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]           ctrl_a;
        logic [7:0]           ctrl_b;
        logic [15:0]          counter_value;
        logic [15:0]          capture_value;
        logic [15:0]          compare_a_value;
        logic [15:0]          compare_a_buf;
        logic                 count_down;
        logic [TMC_PRE_W-1:0] prescale;
        logic                 ext_prev;
        logic                 cap_prev;
        logic [1:0]           status;
        logic [1:0]           mask;
        logic [31:0]          rdata;
    } tmc_state_t;

    tmc_state_t st_reg;
    tmc_state_t st_next;

    logic       cap_filtered;
    logic [3:0] waveform_mode;
    tmc_mode_t  md;
    logic [15:0] top_value;
    logic        tick;
    logic        capture_hit;
    logic        at_top;
    logic        at_bottom;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;
    logic        capture_disabled;
    logic        rd_setup;
    logic [11:0] reg_index;

    // ------------------------------------------------------------
    // capture filter
    // ------------------------------------------------------------
    tmc_capture_filter #(
        .LEN       (TMC_FILTER_LEN)
    ) u_filter (
        .clk       (REF_CLK),
        .rst       (SYS_RST),
        .enable    (st_reg.ctrl_b[TMC_B_FILTER_BIT]),
        .sample_in (CAPTURE_IN),
        .level_out (cap_filtered)
    );

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    assign waveform_mode = {st_reg.ctrl_b[TMC_B_MODE_HI:TMC_B_MODE_LO], st_reg.ctrl_a[1:0]};

    always_comb begin
        md = '{kind: TMC_KIND_NORMAL, top_src: TMC_TOP_FIXED, top_fixed: TMC_TOP_MAX,
               load_at_top: 1'b0, load_at_bottom: 1'b0, flag_at_top: 1'b1,
               flag_at_bottom: 1'b0, reserved: 1'b0};
        case (waveform_mode)
            4'h1, 4'h2, 4'h3: begin
                md.kind        = TMC_KIND_PHASE;
                md.top_fixed   = (waveform_mode == 4'h1) ? TMC_TOP_8BIT :
                                 (waveform_mode == 4'h2) ? TMC_TOP_9BIT : TMC_TOP_10BIT;
                md.load_at_top = 1'b1;
                md.flag_at_top = 1'b0;
                md.flag_at_bottom = 1'b1;
            end
            4'h4, 4'hc: begin
                md.kind    = TMC_KIND_CLEAR;
                md.top_src = (waveform_mode == 4'h4) ? TMC_TOP_COMPARE : TMC_TOP_CAPTURE;
                md.flag_at_top = 1'b0;
            end
            4'h5, 4'h6, 4'h7: begin
                md.kind      = TMC_KIND_FAST;
                md.top_fixed = (waveform_mode == 4'h5) ? TMC_TOP_8BIT :
                               (waveform_mode == 4'h6) ? TMC_TOP_9BIT : TMC_TOP_10BIT;
                md.load_at_bottom = 1'b1;
            end
            4'h8, 4'h9: begin
                md.kind    = TMC_KIND_PHASE;
                md.top_src = waveform_mode[0] ? TMC_TOP_COMPARE : TMC_TOP_CAPTURE;
                md.load_at_bottom = 1'b1;
                md.flag_at_top    = 1'b0;
                md.flag_at_bottom = 1'b1;
            end
            4'ha, 4'hb: begin
                md.kind    = TMC_KIND_PHASE;
                md.top_src = waveform_mode[0] ? TMC_TOP_COMPARE : TMC_TOP_CAPTURE;
                md.load_at_top    = 1'b1;
                md.flag_at_top    = 1'b0;
                md.flag_at_bottom = 1'b1;
            end
            4'he, 4'hf: begin
                md.kind    = TMC_KIND_FAST;
                md.top_src = waveform_mode[0] ? TMC_TOP_COMPARE : TMC_TOP_CAPTURE;
                md.load_at_bottom = 1'b1;
            end
            4'hd: begin
                md.top_src     = TMC_TOP_NONE;
                md.flag_at_top = 1'b0;
                md.reserved    = 1'b1;
            end
            default: begin
                md.kind = TMC_KIND_NORMAL;
            end
        endcase
    end

    always_comb begin
        case (md.top_src)
            TMC_TOP_CAPTURE: top_value = st_reg.capture_value;
            TMC_TOP_COMPARE: top_value = st_reg.compare_a_value;
            TMC_TOP_FIXED:   top_value = md.top_fixed;
            default:         top_value = TMC_TOP_MAX;
        endcase
    end

    assign capture_disabled = (md.top_src == TMC_TOP_CAPTURE);

    // ------------------------------------------------------------
    // clock select and prescaler
    // ------------------------------------------------------------
    always_comb begin
        case (st_reg.ctrl_b[TMC_B_CSEL_HI:0])
            3'h1: tick = 1'b1;
            3'h2: tick = (st_reg.prescale[2:0] == 3'(TMC_DIV_8 - 1));
            3'h3: tick = (st_reg.prescale[5:0] == 6'(TMC_DIV_64 - 1));
            3'h4: tick = (st_reg.prescale[7:0] == 8'(TMC_DIV_256 - 1));
            3'h5: tick = (st_reg.prescale == TMC_PRE_W'(TMC_DIV_1024 - 1));
            3'h6: tick = st_reg.ext_prev && !EXT_COUNT_IN;
            3'h7: tick = !st_reg.ext_prev && EXT_COUNT_IN;
            default: tick = 1'b0;
        endcase
    end

    assign at_top    = (st_reg.counter_value == top_value);
    assign at_bottom = (st_reg.counter_value == 16'h0000);

    // capture edge on the filtered level
    assign capture_hit = !capture_disabled &&
                         (st_reg.ctrl_b[TMC_B_EDGE_BIT] ? (!st_reg.cap_prev && cap_filtered)
                                                        : (st_reg.cap_prev && !cap_filtered));

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_en = PSEL && PENABLE && !PWRITE;
    assign rd_setup = PSEL && !PENABLE && !PWRITE;
    // word-aligned only; a misaligned address decodes to nothing
    assign reg_index = (PADDR[1:0] == 2'b00) ? {2'b00, PADDR[11:2]} : 12'hfff;
    always_comb begin
        case (reg_index)
            TMC_OFS_CTRL_A, TMC_OFS_CTRL_B, TMC_OFS_COUNTER, TMC_OFS_CAPTURE,
            TMC_OFS_COMPARE_A, TMC_OFS_STATUS, TMC_OFS_MASK: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0] ev;
        ev      = 2'b00;
        st_next = st_reg;
        st_next.prescale = (st_reg.ctrl_b[TMC_B_CSEL_HI:0] == 3'h0) ? '0 : st_reg.prescale + 1'b1;
        st_next.ext_prev = EXT_COUNT_IN;
        st_next.cap_prev = cap_filtered;

        if (tick && !md.reserved) begin
            if (md.kind == TMC_KIND_PHASE) begin
                if (!st_reg.count_down) begin
                    if (at_top) begin
                        st_next.count_down    = 1'b1;
                        st_next.counter_value = st_reg.counter_value - 16'h0001;
                    end else begin
                        st_next.counter_value = st_reg.counter_value + 16'h0001;
                    end
                end else if (at_bottom) begin
                    st_next.count_down    = 1'b0;
                    st_next.counter_value = 16'h0001;
                end else begin
                    st_next.counter_value = st_reg.counter_value - 16'h0001;
                end
            end else if (at_top) begin
                st_next.counter_value = 16'h0000;
            end else begin
                st_next.counter_value = st_reg.counter_value + 16'h0001;
            end
            if ((md.load_at_top && at_top) || (md.load_at_bottom && at_bottom)) begin
                st_next.compare_a_value = st_reg.compare_a_buf;
            end
            if ((md.flag_at_top && at_top) || (md.flag_at_bottom && at_bottom && st_reg.count_down) ||
                (md.kind == TMC_KIND_CLEAR && st_reg.counter_value == TMC_TOP_MAX)) begin
                ev[TMC_ST_OVERFLOW] = 1'b1;
            end
        end

        if (capture_hit) begin
            st_next.capture_value = st_reg.counter_value;
            ev[TMC_ST_CAPTURE]    = 1'b1;
        end

        if (wr_en) begin
            case (reg_index)
                TMC_OFS_CTRL_A:  st_next.ctrl_a = {6'h00, PWDATA[1:0]};
                TMC_OFS_CTRL_B:  st_next.ctrl_b = PWDATA[7:0] & TMC_B_WRITE_MASK;
                TMC_OFS_COUNTER: st_next.counter_value = PWDATA[15:0];
                TMC_OFS_CAPTURE: st_next.capture_value = PWDATA[15:0];
                TMC_OFS_COMPARE_A: begin
                    st_next.compare_a_buf = PWDATA[15:0];
                    if (md.kind == TMC_KIND_NORMAL || md.kind == TMC_KIND_CLEAR) begin
                        st_next.compare_a_value = PWDATA[15:0];
                    end
                end
                TMC_OFS_MASK:    st_next.mask = PWDATA[1:0];
                default:         st_next.mask = st_reg.mask;
            endcase
        end

        // read data is captured in the setup cycle and presented from the register
        st_next.rdata = 32'h0000_0000;
        if (rd_setup) begin
            case (reg_index)
                TMC_OFS_CTRL_A:    st_next.rdata = {24'h000000, st_reg.ctrl_a};
                TMC_OFS_CTRL_B:    st_next.rdata = {24'h000000, st_reg.ctrl_b};
                TMC_OFS_COUNTER:   st_next.rdata = {16'h0000, st_reg.counter_value};
                TMC_OFS_CAPTURE:   st_next.rdata = {16'h0000, st_reg.capture_value};
                TMC_OFS_COMPARE_A: st_next.rdata = {16'h0000, st_reg.compare_a_buf};
                TMC_OFS_STATUS:    st_next.rdata = {30'h00000000, st_reg.status};
                TMC_OFS_MASK:      st_next.rdata = {30'h00000000, st_reg.mask};
                default:           st_next.rdata = 32'h0000_0000;
            endcase
        end

        // read clears only the bits it returned; a new event in the same cycle wins
        if (rd_en && reg_index == TMC_OFS_STATUS) begin
            st_next.status = (st_reg.status & ~st_reg.rdata[1:0]) | ev;
        end else begin
            st_next.status = st_reg.status | ev;
        end
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_reg        <= '0;
            st_reg.ctrl_a <= TMC_CTRL_RESET;
            st_reg.ctrl_b <= TMC_CTRL_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_ok;
    assign PRDATA  = st_reg.rdata;
    assign IRQ     = |(st_reg.status & st_reg.mask);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_stop_no_count: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        ($past(st_reg.ctrl_b[2:0]) == 3'h0 && !$past(wr_en)) |-> $stable(st_reg.counter_value))
        else $error("counter moved with no clock source");
    a_capture_copy: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        capture_hit && !(wr_en && reg_index == TMC_OFS_CAPTURE)
            |=> (st_reg.capture_value == $past(st_reg.counter_value)) && st_reg.status[TMC_ST_CAPTURE])
        else $error("capture did not copy counter or set flag");
    a_capture_off: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        capture_disabled |-> !capture_hit)
        else $error("capture fired while capture value is TOP");
    a_edge_rise: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        capture_hit |-> (cap_filtered == st_reg.ctrl_b[TMC_B_EDGE_BIT]))
        else $error("capture on wrong edge");
    a_irq_level: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (st_reg.status[TMC_ST_CAPTURE] && st_reg.mask[TMC_ST_CAPTURE]) |-> IRQ)
        else $error("capture interrupt missing");
    a_bit5_zero: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        st_reg.ctrl_b[5] == 1'b0)
        else $error("control b bit 5 set");
    a_fast_wrap: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (tick && md.kind == TMC_KIND_FAST && md.top_src == TMC_TOP_FIXED && at_top && !wr_en)
            |=> st_reg.counter_value == 16'h0000 && st_reg.status[TMC_ST_OVERFLOW])
        else $error("fast mode did not wrap at fixed top");
    a_phase_turn: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (tick && md.kind == TMC_KIND_PHASE && at_top && !st_reg.count_down && !wr_en)
            |=> st_reg.count_down)
        else $error("phase mode did not turn at top");
    a_prescale_8: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (st_reg.ctrl_b[2:0] == 3'h2 && tick) |-> st_reg.prescale[2:0] == 3'h7)
        else $error("divide by 8 tick misplaced");
    a_clear_max_flag: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (tick && md.kind == TMC_KIND_CLEAR && st_reg.counter_value == TMC_TOP_MAX)
            |=> st_reg.status[TMC_ST_OVERFLOW])
        else $error("clear mode did not flag overflow at max");
    a_capture_sticky: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (st_reg.status[TMC_ST_CAPTURE] && !(rd_en && reg_index == TMC_OFS_STATUS))
            |=> st_reg.status[TMC_ST_CAPTURE])
        else $error("capture flag dropped without a status read");
    c_clear_wrap: cover property (@(posedge REF_CLK) tick && md.kind == TMC_KIND_CLEAR && at_top);
    c_capture: cover property (@(posedge REF_CLK) capture_hit);
    c_irq: cover property (@(posedge REF_CLK) IRQ);
    c_phase_turn: cover property (@(posedge REF_CLK) st_reg.count_down && !$past(st_reg.count_down));
    c_ext_tick: cover property (@(posedge REF_CLK) tick && st_reg.ctrl_b[2:1] == 2'b11);
endmodule

/* tb/tmc_pin_model.sv */
// partner model: capture pin and external count pin, driven from bench requests
`timescale 1ns/1ps
module tmc_pin_model (
    input  wire logic clk,
    input  wire logic cap_req,
    input  wire logic ext_req,
    output logic      cap_pin = 1'b0,
    output logic      ext_pin = 1'b0
);
    // ------------------------------------------------------------
    // pins move just after a rising edge, as a synchronous source would
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cap_pin <= cap_req;
        ext_pin <= ext_req;
    end
endmodule

/* tb/tmc_timer_ctrl_tb.sv */
// testbench: register access, clock select, external count, capture and mode TOP checks
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module tmc_timer_ctrl_tb;
    import tmc_pkg::*;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, cap_req = 0, ext_req = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdata, seed = 32'd76353;
    logic        pready, pslverr, irq, rerr, cap_pin, ext_pin;
    logic [15:0] v0, v1, top;
    logic [3:0]  c;
    int          num_errors = 0, checks_done = 0;
    int          divs [5] = '{1, TMC_DIV_8, TMC_DIV_64, TMC_DIV_256, TMC_DIV_1024};
    logic [3:0]  codes [9] = '{1, 2, 3, 4, 5, 6, 7, 11, 15};

    always #5 clk = ~clk;

    tmc_timer_ctrl i_dut (.REF_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CAPTURE_IN(cap_pin), .EXT_COUNT_IN(ext_pin), .IRQ(irq));
    tmc_pin_model i_pins (.clk(clk), .cap_req(cap_req), .ext_req(ext_req), .cap_pin(cap_pin), .ext_pin(ext_pin));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk); psel <= 1; penable <= 0; pwrite <= w; paddr <= {a[9:0], 2'b00}; pwdata <= d;
        @(posedge clk); penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin @(posedge clk); n++; end
        if (n >= 50) num_errors++;
        rdata = prdata; rerr = pslverr;
        psel <= 0; penable <= 0;
    endtask

    task automatic pins(input logic cp, input logic ep, input int n);
        @(posedge clk); cap_req <= cp; ext_req <= ep;
        repeat (n) @(posedge clk);
    endtask

    // counter is stopped, so the captured value is known in advance
    task automatic cap_case(input logic [7:0] ctl, input int hi, input logic fire);
        seed = lfsr_next(seed); v0 = seed[15:0];
        apb(1, TMC_OFS_CTRL_B, {24'h0, ctl});
        apb(1, TMC_OFS_COUNTER, {16'h0, v0});
        pins(~ctl[6], 0, 8);
        apb(0, TMC_OFS_STATUS, 0);
        pins(ctl[6], 0, hi);
        pins(~ctl[6], 0, 10);
        `CHK("irq", fire, irq)
        apb(0, TMC_OFS_STATUS, 0); `CHK("capture flag", fire, rdata[TMC_ST_CAPTURE])
        if (fire) begin apb(0, TMC_OFS_CAPTURE, 0); `CHK("capture value", v0, rdata[15:0]) end
        `CHK("irq cleared", 1'b0, irq)
    endtask

    task automatic results();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        #600000;
        num_errors++;
        results();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        apb(0, TMC_OFS_CTRL_B, 0); `CHK("ctrl b reset", TMC_CTRL_RESET, rdata[7:0])
        repeat (4) begin
            seed = lfsr_next(seed);
            apb(1, TMC_OFS_CTRL_B, {24'h0, seed[7:0]});
            apb(0, TMC_OFS_CTRL_B, 0); `CHK("ctrl b", seed[7:0] & TMC_B_WRITE_MASK, rdata[7:0])
        end
        apb(0, 12'h0c0, 0); `CHK("unmapped err", 1'b1, rerr)
        `CHK("unmapped data", 32'h0, rdata)
        for (int i = 0; i < 6; i++) begin
            apb(1, TMC_OFS_CTRL_B, i);
            apb(0, TMC_OFS_COUNTER, 0); v0 = rdata[15:0];
            repeat (1021) @(posedge clk);
            apb(0, TMC_OFS_COUNTER, 0); v1 = rdata[15:0];
            `CHK("ticks", (i == 0) ? 16'h0 : 16'(1024 / divs[(i > 0) ? i - 1 : 0]), v1 - v0)
        end
        for (int e = 6; e < 8; e++) begin
            apb(1, TMC_OFS_CTRL_B, e);
            apb(0, TMC_OFS_COUNTER, 0); v0 = rdata[15:0];
            repeat (5) begin pins(0, 1, 2); pins(0, 0, 2); end
            apb(0, TMC_OFS_COUNTER, 0); `CHK("ext count", v0 + 16'h5, rdata[15:0])
        end
        apb(1, TMC_OFS_MASK, 32'h1);
        cap_case(8'h40, 3, 1);
        cap_case(8'h00, 3, 1);
        cap_case(8'hc0, 2, 0);
        cap_case(8'hc0, 6, 1);
        cap_case(8'h58, 6, 0);
        apb(1, TMC_OFS_CTRL_B, 0);
        apb(1, TMC_OFS_COMPARE_A, 32'h40);
        // ctrl a goes first so no step passes through the reserved code
        foreach (codes[i]) begin
            c = codes[i];
            top = (c == 1 || c == 5) ? TMC_TOP_8BIT : (c == 2 || c == 6) ? TMC_TOP_9BIT :
                  (c == 3 || c == 7) ? TMC_TOP_10BIT : 16'h0040;
            apb(1, TMC_OFS_CTRL_A, {30'h0, c[1:0]});
            apb(1, TMC_OFS_CTRL_B, {27'h0, c[3:2], 3'b001});
            apb(1, TMC_OFS_COUNTER, 0);
            apb(0, TMC_OFS_STATUS, 0);
            repeat (2200) @(posedge clk);
            apb(0, TMC_OFS_COUNTER, 0); `CHK("within top", 1'b1, rdata[15:0] <= top)
            apb(0, TMC_OFS_STATUS, 0);
            `CHK("overflow flag", c != 4, rdata[TMC_ST_OVERFLOW])
        end
        results();
    end
endmodule
